// ---- hw/dctom_monitor.sv ----
// Dual channel torque-off monitor with status registers and interrupt.
module dctom_monitor #(
	parameter int unsigned MISMATCH_CYC = dctom_pkg::MISMATCH_CYC,
	parameter int unsigned REARM_CYC    = dctom_pkg::REARM_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        safety_enable_input_a,
	input  wire logic        safety_enable_input_b,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             gate_drive_enable,
	output logic             stop_request_flag,
	output logic             torque_off_inhibit_reason,
	output logic             channel_mismatch_fault,
	output logic             safety_drive_fault,
	output logic             irq
);
	localparam int unsigned W = dctom_pkg::CNT_W;
	localparam logic [W-1:0] MIS_LIM = W'(MISMATCH_CYC);
	localparam logic [W-1:0] REARM_LIM = W'(REARM_CYC);

	logic        in_a;
	logic        in_b;
	logic [W-1:0] diff_cnt_r;
	logic [W-1:0] off_cnt_r;
	logic [W-1:0] on_cnt_r;
	logic        rearm_seen_r;
	logic        both_on_d_r;
	logic        reset_ok_r;
	logic [dctom_pkg::EV_W-1:0] event_r;
	logic [dctom_pkg::EV_W-1:0] mask_r;

	// Pins come from the safety circuit, outside our clock domain.
	dctom_sync u_sync_a (.clk(clk), .sys_rst(sys_rst), .pin(safety_enable_input_a),
		.level(in_a));
	dctom_sync u_sync_b (.clk(clk), .sys_rst(sys_rst), .pin(safety_enable_input_b),
		.level(in_b));

	wire any_off   = ~in_a | ~in_b;
	wire both_on   = in_a & in_b;
	wire both_off  = ~in_a & ~in_b;
	wire differ    = in_a ^ in_b;
	wire mis_hit   = differ && (diff_cnt_r >= MIS_LIM);
	wire off_long  = both_off && (off_cnt_r >= MIS_LIM);
	wire on_edge   = both_on & ~both_on_d_r;
	wire rearm_ok  = on_edge && rearm_seen_r && (on_cnt_r <= REARM_LIM);
	wire wr_ctrl   = reg_wr && (reg_addr == dctom_pkg::ADDR_CTRL);
	wire fault_rst = wr_ctrl && reg_wdata[dctom_pkg::CTRL_RESET] && reset_ok_r;
	wire stop_set  = any_off & ~stop_request_flag;
	wire [dctom_pkg::EV_W-1:0] ev_hit = {rearm_ok, mis_hit & ~channel_mismatch_fault,
		stop_set};
	wire [7:0] status_word = {1'b0, reset_ok_r, in_b, in_a, safety_drive_fault,
		channel_mismatch_fault, torque_off_inhibit_reason, stop_request_flag};
	wire [7:0] rd_mux = (reg_addr == dctom_pkg::ADDR_STATUS) ? status_word :
		(reg_addr == dctom_pkg::ADDR_EVENT) ? {5'h00, event_r} :
		(reg_addr == dctom_pkg::ADDR_MASK) ? {5'h00, mask_r} : 8'h00;

	// Difference timer runs while channels disagree, saturating at the limit.
	always_ff @(posedge clk) begin
		if (sys_rst || !differ) begin
			diff_cnt_r <= '0;
		end else if (diff_cnt_r < MIS_LIM) begin
			diff_cnt_r <= diff_cnt_r + 1'b1;
		end
	end

	// Both-off timer qualifies a fault reset.
	always_ff @(posedge clk) begin
		if (sys_rst || !both_off) begin
			off_cnt_r <= '0;
		end else if (off_cnt_r < MIS_LIM) begin
			off_cnt_r <= off_cnt_r + 1'b1;
		end
	end

	// Re-energise window timer starts when the first channel comes back on.
	// It holds at limit+1 so a late second channel is seen as too late.
	always_ff @(posedge clk) begin
		if (sys_rst || both_off || both_on) begin
			on_cnt_r <= '0;
		end else if (on_cnt_r <= REARM_LIM) begin
			on_cnt_r <= on_cnt_r + 1'b1;
		end
	end

	// A clean restart needs both channels to have been off together first.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rearm_seen_r <= 1'b0;
			both_on_d_r  <= 1'b1;
		end else begin
			both_on_d_r <= both_on;
			if (both_off) begin
				rearm_seen_r <= 1'b1;
			end else if (on_edge) begin
				rearm_seen_r <= 1'b0;
			end
		end
	end

	// Stop request and inhibit reason; gate drive drops the cycle after an input is seen
	// off, far below the 12 ms budget even with the synchroniser delay.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stop_request_flag         <= 1'b1;
			torque_off_inhibit_reason <= 1'b1;
			gate_drive_enable         <= 1'b0;
		end else begin
			if (any_off) begin
				stop_request_flag <= 1'b1;
			end else if (rearm_ok && !channel_mismatch_fault) begin
				stop_request_flag <= 1'b0;
			end
			torque_off_inhibit_reason <= any_off;
			gate_drive_enable <= both_on && !stop_request_flag && !channel_mismatch_fault
				&& !any_off;
		end
	end

	// Mismatch fault latches; only a qualified reset clears it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			channel_mismatch_fault <= 1'b0;
			safety_drive_fault     <= 1'b0;
			reset_ok_r             <= 1'b0;
		end else begin
			reset_ok_r <= off_long;
			if (mis_hit) begin
				channel_mismatch_fault <= 1'b1;
				safety_drive_fault     <= 1'b1;
			end else if (fault_rst) begin
				channel_mismatch_fault <= 1'b0;
				safety_drive_fault     <= 1'b0;
			end
		end
	end

	// Sticky events: a new hit wins over a write-one clear in the same cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			event_r <= '0;
			mask_r  <= dctom_pkg::MASK_RST;
			irq     <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == dctom_pkg::ADDR_EVENT) begin
				event_r <= (event_r & ~reg_wdata[dctom_pkg::EV_W-1:0]) | ev_hit;
			end else begin
				event_r <= event_r | ev_hit;
			end
			if (reg_wr && reg_addr == dctom_pkg::ADDR_MASK) begin
				mask_r <= reg_wdata[dctom_pkg::EV_W-1:0];
			end
			irq <= |(event_r & mask_r);
		end
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Gate drive is off from the cycle after an input is seen off.
	a_gate_off_input: assert property (@(posedge clk) disable iff (sys_rst)
		any_off |=> !gate_drive_enable)
		else $error("gate drive on while an input is off");

	// Stop request is set one cycle after any input drops.
	a_stop_set_flag: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(both_on) |=> stop_request_flag && torque_off_inhibit_reason)
		else $error("stop request not set after input dropped");

	// Gate drive falls within two cycles after a channel A drop leaves the synchroniser.
	a_stop_response: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(in_a) |-> ##[1:2] !gate_drive_enable)
		else $error("gate drive slow to drop");

	// Fault follows a saturated difference timer.
	a_mismatch_raise: assert property (@(posedge clk) disable iff (sys_rst)
		mis_hit |=> channel_mismatch_fault && !gate_drive_enable)
		else $error("mismatch fault not raised");

	// Fault only drops through a qualified reset.
	a_fault_latched: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(channel_mismatch_fault) |-> $past(reset_ok_r))
		else $error("mismatch fault cleared without qualified reset");

	// Stop flag only clears at a timely second-channel return.
	a_stop_clear: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(stop_request_flag) |-> $past(on_cnt_r) <= REARM_LIM)
		else $error("stop request cleared outside rearm window");

	// No fault while channels have differed for less than the window.
	a_no_early_fault: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(channel_mismatch_fault) |-> $past(diff_cnt_r) == MIS_LIM)
		else $error("mismatch fault before one second");

	// Clearing needs a both-off phase first.
	a_rearm_needs_off: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(stop_request_flag) |-> $past(rearm_seen_r))
		else $error("restart without both channels off");
endmodule

// ---- hw/dctom_pkg.sv ----
// Package of constants for the dual channel torque-off monitor.
package dctom_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned MISMATCH_MS     = 1000;
	localparam int unsigned STOP_LIMIT_MS   = 12;
	localparam int unsigned REARM_MS        = 100;
	localparam int unsigned MISMATCH_CYC    = CLK_HZ / 1000 * MISMATCH_MS;
	localparam int unsigned REARM_CYC       = CLK_HZ / 1000 * REARM_MS;
	localparam int unsigned STOP_LIMIT_CYC  = CLK_HZ / 1000 * STOP_LIMIT_MS;
	localparam int unsigned CNT_W           = 26;
	// Register offsets on the plain port.
	localparam logic [3:0] ADDR_STATUS      = 4'h0;
	localparam logic [3:0] ADDR_EVENT       = 4'h1;
	localparam logic [3:0] ADDR_MASK        = 4'h2;
	localparam logic [3:0] ADDR_CTRL        = 4'h3;
	// Status word bit positions.
	localparam int unsigned ST_STOP         = 0;
	localparam int unsigned ST_INHIBIT      = 1;
	localparam int unsigned ST_MISMATCH     = 2;
	localparam int unsigned ST_DRVFLT       = 3;
	localparam int unsigned ST_IN_A         = 4;
	localparam int unsigned ST_IN_B         = 5;
	localparam int unsigned ST_RESET_OK     = 6;
	// Event bit positions.
	localparam int unsigned EV_STOP         = 0;
	localparam int unsigned EV_MISMATCH     = 1;
	localparam int unsigned EV_CLEAR        = 2;
	localparam int unsigned EV_W            = 3;
	localparam int unsigned CTRL_RESET      = 0;
	localparam logic [EV_W-1:0] MASK_RST    = 3'h0;
endpackage

// ---- hw/dctom_sync.sv ----
// Two flip-flop synchroniser for one pin level.
module dctom_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      level
);
	logic meta_r;

	// First stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= 1'b0;
			level  <= 1'b0;
		end else begin
			meta_r <= pin;
			level  <= meta_r;
		end
	end
endmodule

// ---- dv/dctom_partner.sv ----
// Model of the external safety circuit that drives both enable channels.
module dctom_partner (
	input  wire logic clk,
	output logic      ch_a,
	output logic      ch_b
);
	timeunit 1ns;
	timeprecision 1ps;

	// Both channels start de-energised, as after a power-up of the safety circuit.
	initial begin
		ch_a = 1'b0;
		ch_b = 1'b0;
	end

	// Moves one channel, then the other after gap cycles when both is set; without both only
	// the lone channel moves, so a channel can return on while its partner stayed on.
	task automatic step(input logic lvl, input logic b_first, input int gap, input logic both);
		@(posedge clk);
		if (b_first)
			ch_b <= lvl;
		else
			ch_a <= lvl;
		repeat (gap) @(posedge clk);
		// Only the channel not yet moved is driven, so no pin is assigned twice in one step.
		if (both && b_first) begin
			ch_a <= lvl;
		end else if (both) begin
			ch_b <= lvl;
		end
	endtask
endmodule

// ---- dv/dctom_monitor_tb_top.sv ----
// Self-checking bench for the dual channel torque-off monitor.
module dctom_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MC = 50;
	localparam int RC = 10;
	logic       clk, sys_rst, reg_wr, reg_rd, a, b, gate, stop, inh, flt, dflt, irq, fb;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int         n_errors, num_checks, cyc, m_a, m_b, e_stop, e_flt;

	dctom_partner u_partner (.clk(clk), .ch_a(a), .ch_b(b));
	dctom_monitor #(.MISMATCH_CYC(MC), .REARM_CYC(RC)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .safety_enable_input_a(a), .safety_enable_input_b(b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .gate_drive_enable(gate), .stop_request_flag(stop),
		.torque_off_inhibit_reason(inh), .channel_mismatch_fault(flt),
		.safety_drive_fault(dflt), .irq(irq));

	// A 40 ns clock; the cycle counter cuts a hang short well past the planned run.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// Compares the stop, inhibit, both fault and gate output levels with the model state.
	task automatic outs();
		chk("stop", stop, 8'(e_stop));
		chk("inhibit", inh, 8'(!(m_a && m_b)));
		chk("mismatch", flt, 8'(e_flt));
		chk("drive_fault", dflt, 8'(e_flt));
		chk("gate", gate, 8'(m_a && m_b && !e_stop && !e_flt));
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("rdata", reg_rdata, e);
	endtask
	// Drives the partner and keeps the model's copy of the pin levels.
	task automatic move(input int lvl, input logic f, input int gap, input logic both);
		u_partner.step(lvl[0], f, gap, both);
		if (both || f)
			m_b = lvl;
		if (both || !f)
			m_a = lvl;
	endtask

	// Main sequence; waits of 5 cycles sit far inside the 12 ms turn-off limit.
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{n_errors, num_checks, m_a, m_b, e_flt} = '0;
		e_stop = 1;
		sys_rst = 1'b1;
		void'($urandom(20));
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		settle(1);
		outs();
		rd(dctom_pkg::ADDR_STATUS, 8'h03);
		rd(4'hf, 8'h00);
		move(1, 1'($urandom), 1 + $urandom % (RC - 2), 1);
		e_stop = 0;
		settle(6);
		outs();
		fb = 1'($urandom);
		move(0, fb, 0, 0);
		e_stop = 1;
		settle(5);
		outs();
		move(0, fb, 1 + $urandom % 20, 1);
		move(1, fb, RC + 10, 1);
		settle(6);
		outs();
		move(0, fb, 2, 1);
		move(1, !fb, 3, 1);
		e_stop = 0;
		settle(6);
		outs();
		wr(dctom_pkg::ADDR_EVENT, 8'h07);
		fb = 1'($urandom);
		move(0, fb, 0, 0);
		e_stop = 1;
		e_flt = 1;
		settle(MC + 10);
		outs();
		rd(dctom_pkg::ADDR_EVENT, 8'h03);
		chk("irq", irq, 8'h00);
		wr(dctom_pkg::ADDR_MASK, 8'h02);
		settle(3);
		chk("irq", irq, 8'h01);
		wr(dctom_pkg::ADDR_EVENT, 8'h02);
		settle(3);
		chk("irq", irq, 8'h00);
		move(1, fb, 0, 0);
		settle(6);
		outs();
		wr(dctom_pkg::ADDR_CTRL, 8'h01);
		settle(3);
		outs();
		move(0, fb, 0, 1);
		settle(MC + 10);
		rd(dctom_pkg::ADDR_STATUS, 8'h4f);
		wr(dctom_pkg::ADDR_CTRL, 8'h01);
		e_flt = 0;
		settle(3);
		outs();
		move(1, fb, 2, 1);
		e_stop = 0;
		settle(6);
		outs();
		rd(dctom_pkg::ADDR_EVENT, 8'h05);
		rd(dctom_pkg::ADDR_MASK, 8'h02);
		final_report();
	end
endmodule
